// ===== logic/scd_spi_core.sv
/*
 * Serial peripheral interface core: master clock divider, data register with
 * transmit and receive buffers, master and slave shifting of 8-bit frames.
 * Assumes the register bus runs on sys_clk; all link pins are asynchronous
 * and are synchronised; the pads resolve each pin from its output enable.
 */
`timescale 1ns/100ps

// How it works
// - Master clock is core_clock over 2*(divisor+1).
// - Every divisor 0..255 used; zero halves rate.
// - Divisor drives the clock pin only as master.
// - Data write loads transmit buffer; master starts.
// - Data read returns the receive buffer.
// - Polarity one inverts the clock, timing unchanged.
// - Slave output valid within four after select.
// - Slave output released within four after deselect.
// - Slave output updates within four after shift.
// - Phase one: output changes six-eight after last.
// - Slave samples mid-bit; master one before end.
module scd_spi_core
(
    // Clock and reset.
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    // Register bus.
    input  wire scd_pkg::scd_sfr_req_type sfr_req,
    output logic [7:0]                    sfr_rdata,
    // Mode selection.
    input  wire logic                     master_mode,
    input  wire logic                     clock_polarity_sel,
    input  wire logic                     clock_phase_sel,
    // Status.
    output logic                          xfer_busy,
    output logic                          xfer_done,
    // Serial clock pin.
    input  wire logic                     sck_in,
    output logic                          sck_out,
    output logic                          sck_oe,
    // Master-out data pin.
    input  wire logic                     mosi_in,
    output logic                          mosi_out,
    output logic                          mosi_oe,
    // Master-in data pin.
    input  wire logic                     miso_in,
    output logic                          miso_out,
    output logic                          miso_oe,
    // Slave select pin.
    input  wire logic                     nss_n_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [7:0]             clock_divisor_field;
    logic [7:0]             tx_buf;
    logic [7:0]             rx_buf;
    logic [7:0]             shift;
    logic [7:0]             half_cnt;
    logic                   half_ph;
    logic [2:0]             bit_cnt;
    logic [2:0]             tail_cnt;
    scd_pkg::scd_state_type state;
    logic [1:0]             sck_sync;
    logic [1:0]             mosi_sync;
    logic [1:0]             miso_sync;
    logic [1:0]             nss_sync;
    logic                   sck_prev;
    logic                   nss_prev;
    logic                   data_wr;
    logic                   sck_lvl;
    logic                   prev_lvl;
    logic                   lead_edge;
    logic                   trail_edge;
    logic                   samp_edge;
    logic                   shft_edge;
    logic                   nss_fall;
    logic                   half_end;
    logic                   next_sck;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode.

    // A write to the data address is the transfer trigger.
    assign data_wr = sfr_req.wr && (sfr_req.addr == scd_pkg::ADDR_DATA);

    // Software-written registers.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clock_divisor_field <= scd_pkg::DIVISOR_RESET;
            tx_buf              <= scd_pkg::DATA_RESET;
        end
        else
        begin
            if (sfr_req.wr && (sfr_req.addr == scd_pkg::ADDR_DIVISOR))
                clock_divisor_field <= sfr_req.wdata;
            if (data_wr)
                tx_buf <= sfr_req.wdata;
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sfr_rdata <= scd_pkg::DATA_RESET;
        else if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                scd_pkg::ADDR_DATA:    sfr_rdata <= rx_buf;
                scd_pkg::ADDR_DIVISOR: sfr_rdata <= clock_divisor_field;
                default:               sfr_rdata <= scd_pkg::UNMAPPED_READ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is looked at.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sck_sync  <= 2'h0;
            mosi_sync <= 2'h0;
            miso_sync <= 2'h0;
            nss_sync  <= 2'h3;
            sck_prev  <= 1'b0;
            nss_prev  <= 1'b1;
        end
        else
        begin
            sck_sync  <= {sck_sync[0], sck_in};
            mosi_sync <= {mosi_sync[0], mosi_in};
            miso_sync <= {miso_sync[0], miso_in};
            nss_sync  <= {nss_sync[0], nss_n_in};
            sck_prev  <= sck_sync[1];
            nss_prev  <= nss_sync[1];
        end
    end

    // Slave edge detection, normalised so that leading edges leave the idle level.
    assign sck_lvl    = sck_sync[1] ^ clock_polarity_sel;
    assign prev_lvl   = sck_prev ^ clock_polarity_sel;
    assign lead_edge  = sck_lvl & ~prev_lvl;
    assign trail_edge = ~sck_lvl & prev_lvl;
    assign samp_edge  = clock_phase_sel ? trail_edge : lead_edge;
    assign shft_edge  = clock_phase_sel ? lead_edge : trail_edge;
    assign nss_fall   = ~nss_sync[1] & nss_prev;

    // The last cycle of a half period; tolerant of a divisor lowered mid-frame.
    assign half_end   = (half_cnt >= clock_divisor_field);

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer for both master and slave frames.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state     <= scd_pkg::ST_IDLE;
            shift     <= scd_pkg::DATA_RESET;
            rx_buf    <= scd_pkg::DATA_RESET;
            half_cnt  <= 8'h00;
            half_ph   <= 1'b0;
            bit_cnt   <= 3'h0;
            tail_cnt  <= 3'h0;
            miso_out  <= 1'b0;
            xfer_done <= 1'b0;
        end
        else
        begin
            xfer_done <= 1'b0;
            case (state)
                scd_pkg::ST_IDLE:
                begin
                    if (master_mode && data_wr)
                    begin
                        shift    <= sfr_req.wdata;
                        half_cnt <= 8'h00;
                        half_ph  <= 1'b0;
                        bit_cnt  <= 3'h0;
                        state    <= scd_pkg::ST_MASTER;
                    end
                    else if (!master_mode && nss_fall)
                    begin
                        shift    <= tx_buf;
                        miso_out <= tx_buf[7];
                        bit_cnt  <= 3'h0;
                        state    <= scd_pkg::ST_SLAVE;
                    end
                end
                scd_pkg::ST_MASTER:
                begin
                    if (half_end)
                    begin
                        half_cnt <= 8'h00;
                        half_ph  <= ~half_ph;
                        if (half_ph)
                        begin
                            // Sample in the last cycle of the bit; the next bit moves to the top.
                            shift    <= {shift[6:0], miso_sync[1]};
                            if (bit_cnt == scd_pkg::LAST_BIT)
                            begin
                                rx_buf    <= {shift[6:0], miso_sync[1]};
                                xfer_done <= 1'b1;
                                state     <= scd_pkg::ST_IDLE;
                            end
                            else
                                bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                    else
                        half_cnt <= half_cnt + 8'h01;
                end
                scd_pkg::ST_SLAVE:
                begin
                    if (nss_sync[1] || master_mode)
                        state <= scd_pkg::ST_IDLE;
                    else if (samp_edge)
                    begin
                        if (bit_cnt == scd_pkg::LAST_BIT)
                        begin
                            // Frame complete; reload so a following frame sends fresh data.
                            rx_buf    <= {shift[6:0], mosi_sync[1]};
                            shift     <= tx_buf;
                            xfer_done <= 1'b1;
                            bit_cnt   <= 3'h0;
                            if (clock_phase_sel)
                            begin
                                tail_cnt <= scd_pkg::TAIL_WAIT;
                                state    <= scd_pkg::ST_TAIL;
                            end
                        end
                        else
                        begin
                            shift   <= {shift[6:0], mosi_sync[1]};
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                    end
                    else if (shft_edge)
                        miso_out <= shift[7];
                end
                scd_pkg::ST_TAIL:
                begin
                    // Hold the last bit for the required window, then move on.
                    if (nss_sync[1] || master_mode)
                        state <= scd_pkg::ST_IDLE;
                    else if (tail_cnt == scd_pkg::TAIL_LAST)
                    begin
                        miso_out <= shift[7];
                        state    <= scd_pkg::ST_SLAVE;
                    end
                    else
                        tail_cnt <= tail_cnt - 3'h1;
                end
                default:
                    state <= scd_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers; the clock is idle during the first half under phase zero.
    assign next_sck = ((state == scd_pkg::ST_MASTER) && (half_ph ^ clock_phase_sel)) ^ clock_polarity_sel;

    // Registered pin outputs avoid glitches on the clock line.
    // The data pin follows the top shift bit one cycle late, in step with the clock pin,
    // so that it never moves on a sampling edge.
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sck_out <= 1'b0;
            sck_oe   <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe  <= 1'b0;
            miso_oe  <= 1'b0;
        end
        else
        begin
            mosi_out <= shift[7];
            sck_out <= next_sck;
            sck_oe  <= master_mode;
            mosi_oe <= master_mode;
            miso_oe <= !master_mode && !nss_sync[1];
        end
    end

    // Busy while any frame is in progress.
    assign xfer_busy = (state != scd_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and coverage.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_half_period_len: assert property ((state == scd_pkg::ST_MASTER) && $changed(half_ph) && $past(state) == scd_pkg::ST_MASTER |-> $past(half_cnt) == $past(clock_divisor_field)) else $error("Half period length differs from divisor.");
    a_zero_divisor: assert property ((state == scd_pkg::ST_MASTER) && (clock_divisor_field == 8'h00) && (half_cnt == 8'h00) |=> $changed(half_ph)) else $error("Divisor zero does not toggle every cycle.");
    a_slave_no_clock: assert property (!master_mode |=> !sck_oe) else $error("Clock pin driven in slave mode.");
    a_write_starts: assert property ((state == scd_pkg::ST_IDLE) && master_mode && data_wr |=> (state == scd_pkg::ST_MASTER) && (tx_buf == $past(sfr_req.wdata)) ##1 (mosi_out == $past(sfr_req.wdata[7], 2))) else $error("Master write did not start a frame.");
    a_read_rx: assert property (sfr_req.rd && (sfr_req.addr == scd_pkg::ADDR_DATA) |=> sfr_rdata == $past(rx_buf)) else $error("Data read does not return receive buffer.");
    a_idle_polarity: assert property ((state == scd_pkg::ST_IDLE) && ($past(state) == scd_pkg::ST_IDLE) && $stable(clock_polarity_sel) |-> sck_out == clock_polarity_sel) else $error("Idle clock level ignores polarity.");
    a_select_drive: assert property (!master_mode && $fell(nss_sync[1]) |=> ##[0:1] miso_oe) else $error("Slave output not enabled after select.");
    a_deselect_release: assert property ($rose(nss_sync[1]) |=> !miso_oe) else $error("Slave output not released after deselect.");
    a_shift_update: assert property ((state == scd_pkg::ST_SLAVE) && !nss_sync[1] && !master_mode && shft_edge |=> miso_out == $past(shift[7])) else $error("Slave output not updated on shift edge.");
    a_tail_enter: assert property ((state == scd_pkg::ST_SLAVE) && !nss_sync[1] && !master_mode && samp_edge && clock_phase_sel && (bit_cnt == scd_pkg::LAST_BIT) |=> (state == scd_pkg::ST_TAIL) && (tail_cnt == scd_pkg::TAIL_WAIT)) else $error("Last-edge wait not started.");
    a_tail_exit: assert property ((state == scd_pkg::ST_TAIL) && (tail_cnt == scd_pkg::TAIL_LAST) && !nss_sync[1] && !master_mode |=> (state == scd_pkg::ST_SLAVE) && (miso_out == $past(shift[7]))) else $error("Last-edge wait did not end.");
    a_master_sample: assert property ((state == scd_pkg::ST_MASTER) && half_ph && half_end |=> shift[0] == $past(miso_sync[1])) else $error("Master sample not in last bit cycle.");

    c_master_frame: cover property ((state == scd_pkg::ST_MASTER) ##1 xfer_done);
    c_slave_frame: cover property ((state == scd_pkg::ST_SLAVE) ##1 xfer_done);
    c_slave_tail: cover property ((state == scd_pkg::ST_TAIL) ##1 (state == scd_pkg::ST_SLAVE));

endmodule

// ===== logic/scd_pkg.sv
/*
 * Shared constants and types for the serial clock and data block: register
 * addresses, reset values, slave-mode timing counts and the bus request record.
 * Assumes a single system clock of 250 MHz and an 8-bit register bus.
 */
package scd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map and reset values.
    localparam logic [7:0] ADDR_DIVISOR  = 8'hA2;
    localparam logic [7:0] ADDR_DATA     = 8'hA3;
    localparam logic [7:0] DIVISOR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Frame and timing counts in system clock periods; the clock period itself in ns.
    localparam int         CLK_PERIOD_NS     = 4;
    localparam logic [2:0] LAST_BIT          = 3'h7;
    localparam int         SLAVE_OUT_MAX_CYC = 4;
    localparam int         LAST_EDGE_MIN_CYC = 6;
    localparam int         LAST_EDGE_MAX_CYC = 8;
    localparam int         EDGE_DETECT_CYC   = 3;
    // The extra cycle covers a pin edge that lands just before a capture edge.
    localparam logic [2:0] TAIL_WAIT         = 3'(LAST_EDGE_MIN_CYC - EDGE_DETECT_CYC + 1);
    localparam logic [2:0] TAIL_LAST         = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus request, taken in the cycle the strobes are high.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scd_sfr_req_type;

    // Transfer sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MASTER,
        ST_SLAVE,
        ST_TAIL
    } scd_state_type;

endpackage

// ===== dv/scd_slave_model.sv
/*
 * Behavioural serial slave standing on the far side of the core in master mode.
 * Assumes the bench selects it with sel_n and sets polarity and phase while it is idle.
 */
`timescale 1ns/100ps
module scd_slave_model
(
    // Link pins.
    input  wire logic       sck_line,
    input  wire logic       mosi_line,
    output logic            miso_drv,
    // Frame control.
    input  wire logic       sel_n,
    input  wire logic       clock_polarity_sel,
    input  wire logic       clock_phase_sel,
    input  wire logic [7:0] reply_byte,
    output logic [7:0]      heard_byte
);
    int idx = 8;

    initial miso_drv = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Selection presents the first bit at once when the phase is zero.
    always @(negedge sel_n)
    begin
        idx = clock_phase_sel ? 8 : 7;
        if (!clock_phase_sel)
            miso_drv = reply_byte[7];
    end

    // A released line keeps no level, so the last value is inverted.
    always @(posedge sel_n)
        miso_drv = ~miso_drv;

    // Shift edges step the reply at once; from divisor one up that is before the master samples it, at divisor zero too late.
    always @(sck_line)
    begin
        if (!sel_n && ((sck_line != clock_polarity_sel) == clock_phase_sel))
        begin
            idx = idx - 1;
            miso_drv = (idx >= 0) ? reply_byte[idx] : ~miso_drv;
        end
        else if (!sel_n)
            heard_byte = {heard_byte[6:0], mosi_line};
    end
endmodule

// ===== dv/test_spi_clock_data_timing.sv
/*
 * Self-checking bench for the serial clock and data core in both modes.
 * Assumes the core's pads resolve each pin from its output enable, done here.
 */
`timescale 1ns/100ps
module test_spi_clock_data_timing;
    logic                     sys_clk         = 1'b0;
    logic                     sys_rst         = 1'b1;
    scd_pkg::scd_sfr_req_type sfr_req         = '0;
    logic                     master_mode     = 1'b1;
    logic                     clock_polarity_sel = 1'b0;
    logic                     clock_phase_sel = 1'b0;
    logic                     tb_sck          = 1'b0;
    logic                     tb_mosi         = 1'b0;
    logic                     nss_n           = 1'b1;
    logic                     sel_n           = 1'b1;
    logic [7:0]               reply           = 8'h00;
    logic [7:0]               sfr_rdata, heard, got;
    logic                     xfer_busy, xfer_done, model_miso;
    logic                     sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    int                       errors          = 0;
    int                       samples_checked = 0;
    int                       cycles          = 0;
    int                       done_seen       = 0;
    wire                      sck_w  = sck_oe ? sck_out : tb_sck;
    wire                      mosi_w = mosi_oe ? mosi_out : tb_mosi;
    wire                      miso_w = miso_oe ? miso_out : model_miso;

    scd_spi_core scd_spi_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .master_mode(master_mode), .clock_polarity_sel(clock_polarity_sel),
        .clock_phase_sel(clock_phase_sel), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .nss_n_in(nss_n));

    scd_slave_model scd_slave_model_i (.sck_line(sck_w), .mosi_line(mosi_w), .miso_drv(model_miso),
        .sel_n(sel_n), .clock_polarity_sel(clock_polarity_sel), .clock_phase_sel(clock_phase_sel),
        .reply_byte(reply), .heard_byte(heard));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 250 MHz.
    always #2 sys_clk = ~sys_clk;

    // Cycle count for the hang guard, and a tally of frame completions.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (xfer_done === 1'b1)
            done_seen++;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
            errors++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One-cycle write strobe, taken at the next rising edge.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        sfr_req.wr = 1'b0;
    endtask

    // One-cycle read strobe; the answer holds until the next read.
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        sfr_req.rd = 1'b0;
        @(negedge sys_clk);
        d = sfr_rdata;
    endtask

    // Master frame: half periods, edge count, completion time, both data directions.
    task automatic master_frame(input logic [7:0] div, input logic pol, input logic pha,
                                input logic [7:0] tx, input logic [7:0] rx, input bit chk_rx);
        int n, last_t, done_t, half;
        logic prev;
        n = 0;
        last_t = 0;
        done_t = 0;
        half = int'(div) + 1;
        master_mode = 1'b1;
        clock_polarity_sel = pol;
        clock_phase_sel = pha;
        reply = rx;
        reg_wr(scd_pkg::ADDR_DIVISOR, div);
        cyc(2);
        chk("sck idle", 32'(pol), 32'(sck_out));
        chk("mosi oe", 32'd1, 32'(mosi_oe));
        sel_n = 1'b0;
        cyc(2);
        prev = sck_out;
        reg_wr(scd_pkg::ADDR_DATA, tx);
        for (int t = 1; t <= 16 * half + 3; t++)
        begin
            @(negedge sys_clk);
            if (t == 1)
                chk("busy", 32'd1, 32'(xfer_busy));
            if (sck_out !== prev)
            begin
                if (n > 0)
                    chk("sck half period", 32'(half), 32'(t - last_t));
                n++;
                last_t = t;
                prev = sck_out;
            end
            if (xfer_done === 1'b1)
                done_t = t;
        end
        chk("sck edges", 32'd16, 32'(n));
        chk("busy end", 32'd0, 32'(xfer_busy));
        chk("done time", 32'(16 * half), 32'(done_t));
        sel_n = 1'b1;
        chk("mosi byte", 32'(tx), 32'(heard));
        reg_rd(scd_pkg::ADDR_DATA, got);
        if (chk_rx)
            chk("rx byte", 32'(rx), 32'(got));
    endtask

    // Slave frame with the bench as master; each wait is the required minimum or more.
    task automatic slave_frame(input logic [7:0] tx, input logic [7:0] rx, input logic pol, input logic pha);
        int d0;
        master_mode = 1'b0;
        clock_polarity_sel = pol;
        clock_phase_sel = pha;
        tb_sck = pol;
        cyc(2);
        chk("sck oe", 32'd0, 32'(sck_oe));
        chk("mosi oe", 32'd0, 32'(mosi_oe));
        reg_wr(scd_pkg::ADDR_DATA, tx);
        d0 = done_seen;
        nss_n = 1'b0;
        cyc(4);
        chk("miso oe", 32'd1, 32'(miso_oe));
        chk("miso first", 32'(tx[7]), 32'(miso_out));
        for (int i = 7; i >= 0; i--)
        begin
            tb_mosi = rx[i];
            cyc(4);
            tb_sck = ~pol;
            cyc(4);
            if (pha)
                chk("miso bit", 32'(tx[i]), 32'(miso_out));
            cyc(2);
            tb_sck = pol;
            cyc(4);
            if (!pha && i > 0)
                chk("miso bit", 32'(tx[i - 1]), 32'(miso_out));
        end
        cyc(2);
        chk("miso hold", 32'(pha ? tx[0] : tx[7]), 32'(miso_out));
        nss_n = 1'b1;
        cyc(2);
        chk("miso reload", 32'(tx[7]), 32'(miso_out));
        cyc(2);
        chk("miso release", 32'd0, 32'(miso_oe));
        chk("slave done", 32'(d0 + 1), 32'(done_seen));
        reg_rd(scd_pkg::ADDR_DATA, got);
        chk("slave rx", 32'(rx), 32'(got));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, master frames at both divisor limits, then two slave frames.
    initial
    begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(3);
        reg_rd(scd_pkg::ADDR_DIVISOR, got);
        chk("divisor reset", 32'(scd_pkg::DIVISOR_RESET), 32'(got));
        reg_rd(scd_pkg::ADDR_DATA, got);
        chk("data reset", 32'(scd_pkg::DATA_RESET), 32'(got));
        reg_rd(8'h55, got);
        chk("unmapped", 32'(scd_pkg::UNMAPPED_READ), 32'(got));
        master_frame(8'h00, 1'b0, 1'b0, 8'hA5, 8'h3C, 1'b0);
        master_frame(8'h07, 1'b0, 1'b0, 8'h96, 8'hC1, 1'b1);
        master_frame(8'h07, 1'b1, 1'b1, 8'h4E, 8'h27, 1'b1);
        master_frame(8'hFF, 1'b0, 1'b1, 8'h81, 8'h7E, 1'b1);
        slave_frame(8'hC3, 8'h5A, 1'b0, 1'b0);
        slave_frame(8'h96, 8'h3B, 1'b1, 1'b1);
        close_out();
    end
endmodule
